//--- logic/sps_supervisor.sv
// Purpose: Stall prevention supervisor for a motor inverter.
// Assumes: Measurements and parameters are on ref_clk; terminals are pins.
// Notes: Overview of operation follows.
`timescale 1ns/10ps
`include "sps_regs.svh"

module sps_supervisor #(
  parameter int MIN_ON_CYC = `SPS_MIN_ON_MS * `SPS_CLK_KHZ, // Least on-time of the status.
  parameter int TICK_CYC = `SPS_TICK_MS * `SPS_CLK_KHZ, // One timer step of 0.1 s.
  parameter int TRIP_CYC = `SPS_TRIP_MS * `SPS_CLK_KHZ // Stall time at low frequency.
) (
  input wire logic ref_clk, // System clock, 100 MHz.
  input wire logic resetn, // Synchronous reset, active low.
  input wire sps_pkg::sps_params_s params, // Parameter settings.
  input wire logic [15:0] output_current, // Output current, 0.1 % of rated.
  input wire logic [15:0] torque_current, // Torque current, 0.1 % of motor torque.
  input wire logic [15:0] output_freq, // Present output frequency, 0.01 Hz.
  input wire logic [15:0] cmd_freq, // Commanded frequency, 0.01 Hz.
  input wire logic [15:0] max_freq, // Maximum frequency, 0.01 Hz.
  input wire logic regen, // High while the motor regenerates.
  input wire logic regen_avoid_active, // Regeneration avoidance in progress.
  input wire logic ov_stall_active, // Overvoltage stall in progress.
  input wire logic fast_limit_over, // Current above the fast limit.
  input wire logic [6:0] input_terminals, // Input terminal pins.
  output logic [2:0] output_terminals, // Output terminal levels.
  output sps_pkg::sps_action_e ramp_action, // Request to the ramp generator.
  output logic fast_limit_block, // Blocks the inverter output.
  output logic stall_trip_fault, // Sticky stall trip.
  output logic output_shutoff, // Shuts the inverter output off.
  output logic operation_stop // Stops operation on status.
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Lowers a level above the start frequency; returns it unchanged otherwise.
  function automatic logic [15:0] hf_level(input logic [15:0] lvl, input logic [15:0] f66,
                                           input logic [15:0] p23, input logic [15:0] f);
    logic signed [63:0] a;
    logic signed [63:0] b;
    logic signed [63:0] num;
    logic signed [63:0] den;
    logic signed [63:0] res;
    logic signed [63:0] sl; // Level, signed so differences may go negative.
    logic signed [63:0] sp; // Compensation factor, signed; it may sit below 100 %.
    logic signed [63:0] sc; // One hundred percent, signed.
    a = 64'sd0;
    b = 64'sd0;
    num = 64'sd0;
    den = 64'sd0;
    res = 64'(lvl);
    sl = 64'(lvl);
    sp = 64'(p23);
    sc = 64'(`SPS_PCT_100);
    if (p23 != `SPS_CODE_OFF && f > f66 && f != 16'h0000) begin
      a = (64'(f66) * 64'(lvl)) / 64'(f);
      b = (64'(f66) * 64'(lvl)) / 64'(`SPS_F_CEIL);
      num = b * (sl - a) * (sp - sc);
      den = (sl - b) * sc;
      if (den > 64'sd0) begin
        res = a + num / den;
      end
    end
    if (res < 64'sd0) begin
      res = 64'sd0;
    end else if (res > 64'sd65535) begin
      res = 64'sd65535;
    end
    return res[15:0];
  endfunction

  // Tells whether stall action is allowed in a phase for a selection code.
  function automatic logic phase_on(input logic [7:0] code, input sps_pkg::sps_phase_e ph,
                                    input logic rg);
    logic on;
    on = 1'b0;
    if (code == `SPS_SEL_DRV || code == `SPS_SEL_DRV_NF) begin
      on = !rg;
    end else begin
      case (ph)
        sps_pkg::SPS_PH_ACC: on = !code[`SPS_SEL_NO_ACC];
        sps_pkg::SPS_PH_CON: on = !code[`SPS_SEL_NO_CON];
        sps_pkg::SPS_PH_DEC: on = !code[`SPS_SEL_NO_DEC];
        default: on = 1'b0;
      endcase
    end
    return on;
  endfunction

  // ----------------------------------------
  // Terminal synchroniser and second select
  // ----------------------------------------
  logic [6:0] term_meta_ff; // First synchroniser stage.
  logic [6:0] term_sync_ff; // Second synchroniser stage.
  logic second_sel; // Second-function select level.

  // Two flip-flops bring the terminal pins into the clock domain.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      term_meta_ff <= 7'h00;
      term_sync_ff <= 7'h00;
    end else begin
      term_meta_ff <= input_terminals;
      term_sync_ff <= term_meta_ff;
    end
  end

  // Any terminal coded for the second function selects it.
  always_comb begin
    second_sel = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (params.input_terminal_function_codes[i] == `SPS_FN_SECOND && term_sync_ff[i]) begin
        second_sel = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Level, phase and stall detection
  // ----------------------------------------
  sps_pkg::sps_phase_e phase; // Present operating phase.
  logic [15:0] base_level; // Primary or second level.
  logic [15:0] act_level; // Level after high-frequency reduction.
  logic [15:0] quantity; // Compared current.
  logic torq_block; // Torque limit suppressed.
  logic stall_hit; // Stall prevention acts this cycle.
  logic status_cond; // Condition that drives the status.

  // The phase follows the command against the output frequency.
  always_comb begin
    if (cmd_freq > output_freq) begin
      phase = sps_pkg::SPS_PH_ACC;
    end else if (cmd_freq < output_freq) begin
      phase = sps_pkg::SPS_PH_DEC;
    end else begin
      phase = sps_pkg::SPS_PH_CON;
    end
  end

  // Choose the level, reduce it at high frequency, and compare.
  always_comb begin
    base_level = params.stall_level;
    if (second_sel && params.second_stall_level != `SPS_CODE_OFF) begin
      base_level = params.second_stall_level;
    end
    act_level = hf_level(base_level, params.reduction_start_frequency,
                         params.high_freq_compensation_factor, output_freq);
    quantity = params.limit_quantity_switch ? torque_current : output_current;
    torq_block = params.limit_quantity_switch && phase == sps_pkg::SPS_PH_DEC &&
                 output_freq <= `SPS_F_TORQ_MIN;
    stall_hit = base_level != 16'h0000 && quantity > act_level && !torq_block &&
                phase_on(params.per_phase_selection_code, phase, regen);
    status_cond = stall_hit || regen_avoid_active || ov_stall_active;
  end

  // ----------------------------------------
  // Ramp request and fast limit
  // ----------------------------------------
  // Stall action reverses or halts the ramp; raising stops at maximum.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ramp_action <= sps_pkg::SPS_ACT_RUN;
    end else if (!stall_hit) begin
      ramp_action <= sps_pkg::SPS_ACT_RUN;
    end else if (phase == sps_pkg::SPS_PH_DEC ||
                 (params.limit_quantity_switch && regen)) begin
      // Raising the frequency, capped at the maximum frequency.
      ramp_action <= output_freq >= max_freq ? sps_pkg::SPS_ACT_HOLD :
                     sps_pkg::SPS_ACT_ACC;
    end else begin
      ramp_action <= sps_pkg::SPS_ACT_DEC;
    end
  end

  logic fast_en; // Fast-response current limit enabled.

  // Bit 0 disables the fast limit; code 100 disables it during regeneration, code 101 disables it always.
  always_comb begin
    fast_en = !params.per_phase_selection_code[`SPS_SEL_NO_FAST];
    if (params.per_phase_selection_code == `SPS_SEL_DRV) begin
      fast_en = !regen;
    end else if (params.per_phase_selection_code == `SPS_SEL_DRV_NF) begin
      fast_en = 1'b0;
    end
  end

  // Overcurrent with the fast limit on blocks the output.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fast_limit_block <= 1'b0;
    end else begin
      fast_limit_block <= fast_en && fast_limit_over;
    end
  end

  // ----------------------------------------
  // Stall status timing
  // ----------------------------------------
  sps_pkg::sps_state_e state_ff; // Status state.
  logic [31:0] tick_cnt_ff; // Cycles within one 0.1 s step.
  logic [15:0] tenth_cnt_ff; // Elapsed 0.1 s steps.
  logic [31:0] on_cnt_ff; // Cycles spent on.
  logic never_out; // Timer set to never output.
  logic status_on; // Stall status level.

  assign never_out = params.status_output_timer == `SPS_CODE_OFF;
  assign status_on = state_ff == sps_pkg::SPS_ST_ON;

  // Delay, then hold the status for its least time, then follow the level.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_ff <= sps_pkg::SPS_ST_IDLE;
      tick_cnt_ff <= 32'h00000000;
      tenth_cnt_ff <= 16'h0000;
      on_cnt_ff <= 32'h00000000;
    end else if (never_out) begin
      state_ff <= sps_pkg::SPS_ST_IDLE;
    end else begin
      case (state_ff)
        sps_pkg::SPS_ST_IDLE: begin
          tick_cnt_ff <= 32'h00000000;
          tenth_cnt_ff <= 16'h0000;
          on_cnt_ff <= 32'h00000000;
          if (status_cond) begin
            state_ff <= params.status_output_timer == 16'h0000 ? sps_pkg::SPS_ST_ON :
                        sps_pkg::SPS_ST_DELAY;
          end
        end
        sps_pkg::SPS_ST_DELAY: begin
          if (!status_cond) begin
            state_ff <= sps_pkg::SPS_ST_IDLE;
          end else if (tenth_cnt_ff >= params.status_output_timer) begin
            state_ff <= sps_pkg::SPS_ST_ON;
          end else if (tick_cnt_ff >= 32'(TICK_CYC - 1)) begin
            tick_cnt_ff <= 32'h00000000;
            tenth_cnt_ff <= tenth_cnt_ff + 16'h0001;
          end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
          end
        end
        sps_pkg::SPS_ST_ON: begin
          if (on_cnt_ff < 32'(MIN_ON_CYC)) begin
            on_cnt_ff <= on_cnt_ff + 32'h00000001;
          end else if (!status_cond) begin
            state_ff <= sps_pkg::SPS_ST_IDLE;
          end
        end
        default: state_ff <= sps_pkg::SPS_ST_IDLE;
      endcase
    end
  end

  // Terminals show the status in the polarity their code selects.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      output_terminals <= 3'h0;
      operation_stop <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (params.output_terminal_function_codes[i] == `SPS_FN_STALL) begin
          output_terminals[i] <= status_on;
        end else if (params.output_terminal_function_codes[i] == `SPS_FN_STALL_N) begin
          output_terminals[i] <= !status_on;
        end else begin
          output_terminals[i] <= 1'b0;
        end
      end
      operation_stop <= status_on && params.per_phase_selection_code[`SPS_SEL_STOP] &&
                        params.per_phase_selection_code < `SPS_SEL_DRV;
    end
  end

  // ----------------------------------------
  // Stall trip
  // ----------------------------------------
  logic [31:0] trip_cnt_ff; // Cycles stalled at low frequency.

  // A stall held at 1 Hz or below for the trip time sets a sticky fault.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      trip_cnt_ff <= 32'h00000000;
      stall_trip_fault <= 1'b0;
    end else if (!(stall_hit && output_freq <= `SPS_F_TRIP)) begin
      trip_cnt_ff <= 32'h00000000;
    end else if (trip_cnt_ff >= 32'(TRIP_CYC - 1)) begin
      stall_trip_fault <= 1'b1;
    end else begin
      trip_cnt_ff <= trip_cnt_ff + 32'h00000001;
    end
  end

  // The output is shut off on a trip or a fast-limit block.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      output_shutoff <= 1'b0;
    end else begin
      output_shutoff <= stall_trip_fault || (fast_en && fast_limit_over);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  min_on_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    status_on && !never_out && on_cnt_ff < 32'(MIN_ON_CYC) |=> status_on)
    else $error("Status dropped before its least on-time.");
  drop_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    status_on && !status_cond && on_cnt_ff >= 32'(MIN_ON_CYC) |=> !status_on)
    else $error("Status held after the level fell.");
  immed_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_ff == sps_pkg::SPS_ST_IDLE && status_cond &&
    params.status_output_timer == 16'h0000 |=> status_on)
    else $error("Immediate status was delayed.");
  never_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    never_out |=> !status_on)
    else $error("Status shown with the timer set to never.");
  term_pol_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    params.output_terminal_function_codes[1] == `SPS_FN_STALL_N |=>
    output_terminals[1] == !$past(status_on))
    else $error("Negative terminal polarity wrong.");
  torq_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    params.limit_quantity_switch && phase == sps_pkg::SPS_PH_DEC &&
    output_freq <= `SPS_F_TORQ_MIN |=> ramp_action == sps_pkg::SPS_ACT_RUN)
    else $error("Torque limit acted at low frequency.");
  trip_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    stall_trip_fault |=> stall_trip_fault && output_shutoff)
    else $error("Trip not held with output off.");
  zero_lvl_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    base_level == 16'h0000 |=> ramp_action == sps_pkg::SPS_ACT_RUN)
    else $error("Stall action with level zero.");
  status_cv: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(status_on));
  trip_cv: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(stall_trip_fault));
  reverse_cv: cover property (@(posedge ref_clk) disable iff (!resetn)
    ramp_action == sps_pkg::SPS_ACT_ACC);
endmodule

//--- logic/sps_regs.svh
// Purpose: Constants for the stall prevention supervisor.
// Assumes: Currents in 0.1 % units, frequencies in 0.01 Hz, timer in 0.1 s.
// Notes: Times are kept in ms; cycle counts are derived in the module.
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define SPS_CLK_KHZ 100000
`define SPS_MIN_ON_MS 100
`define SPS_TICK_MS 100
`define SPS_TRIP_MS 3000
// ----------------------------------------
// Levels, codes and frequencies
// ----------------------------------------
`define SPS_LEVEL_DEF 16'h05DC
`define SPS_CODE_OFF 16'h270F
`define SPS_PCT_100 16'h03E8
`define SPS_F_TORQ_MIN 16'h01F4
`define SPS_F_TRIP 16'h0064
`define SPS_F_CEIL 16'h9C40
`define SPS_FN_STALL 8'h03
`define SPS_FN_STALL_N 8'h67
`define SPS_FN_SECOND 8'h03
`define SPS_SEL_DRV 8'h64
`define SPS_SEL_DRV_NF 8'h65
// ----------------------------------------
// Per-phase selection code bit positions
// ----------------------------------------
`define SPS_SEL_NO_FAST 0
`define SPS_SEL_NO_ACC 1
`define SPS_SEL_NO_CON 2
`define SPS_SEL_NO_DEC 3
`define SPS_SEL_STOP 4
`endif

//--- logic/sps_pkg.sv
// Purpose: Types shared by the stall prevention supervisor.
// Assumes: Units as in sps_regs.svh.
// Notes: Parameters arrive as one packed struct.
package sps_pkg;
  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  // Operating phase of the frequency ramp.
  typedef enum logic [1:0] {SPS_PH_ACC, SPS_PH_CON, SPS_PH_DEC} sps_phase_e;
  // Request sent back to the ramp generator.
  typedef enum logic [1:0] {SPS_ACT_RUN, SPS_ACT_HOLD, SPS_ACT_DEC, SPS_ACT_ACC} sps_action_e;
  // State of the stall status output.
  typedef enum logic [1:0] {SPS_ST_IDLE, SPS_ST_DELAY, SPS_ST_ON} sps_state_e;
  // ----------------------------------------
  // Parameter bundle
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] stall_level;
    logic [15:0] second_stall_level;
    logic [15:0] high_freq_compensation_factor;
    logic [15:0] reduction_start_frequency;
    logic [7:0] per_phase_selection_code;
    logic [15:0] status_output_timer;
    logic limit_quantity_switch;
    logic [2:0][7:0] output_terminal_function_codes;
    logic [6:0][7:0] input_terminal_function_codes;
  } sps_params_s;
endpackage

//--- dv/sps_drive_model.sv
// Purpose: Behavioural power stage and ramp generator facing the supervisor.
// Assumes: The bench sets targets; the model shows them one edge later.
// Notes: Ramp requests are watched by the bench; frequency is not integrated.
`timescale 1ns/10ps

module sps_drive_model (
  input wire logic ref_clk, // System clock.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic [4:0][15:0] set_val, // Current, torque, output, command, maximum.
  input wire logic [3:0] set_flag, // Regen, avoidance, overvoltage, fast over.
  output logic [15:0] output_current, // Measured output current.
  output logic [15:0] torque_current, // Measured torque current.
  output logic [15:0] output_freq, // Present output frequency.
  output logic [15:0] cmd_freq, // Commanded frequency.
  output logic [15:0] max_freq, // Maximum frequency.
  output logic [3:0] flags // Regen, avoidance, overvoltage, fast over.
);
  // ----------------------------------------
  // Measurement path
  // ----------------------------------------
  // Values land one edge after the bench sets them, like a sampled converter.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      output_current <= 16'h0000;
      torque_current <= 16'h0000;
      output_freq <= 16'h0000;
      cmd_freq <= 16'h0000;
      max_freq <= 16'h0000;
      flags <= 4'h0;
    end else begin
      output_current <= set_val[0];
      torque_current <= set_val[1];
      output_freq <= set_val[2];
      cmd_freq <= set_val[3];
      max_freq <= set_val[4];
      flags <= set_flag;
    end
  end
endmodule

//--- dv/sps_supervisor_bench.sv
// Purpose: Self-checking bench for the stall prevention supervisor.
// Assumes: Short counts: minimum on 16, tick 10, trip 50 cycles.
// Notes: Each step drives targets, waits the fixed latency, then compares.
`timescale 1ns/10ps

module sps_supervisor_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [15:0] hi = 16'h05DD; // Just above the default level.
  localparam logic [15:0] lo = 16'h03E8; // Well below the default level.
  localparam logic [15:0] f30 = 16'h0BB8; // 30 Hz.
  localparam logic [15:0] f40 = 16'h0FA0; // 40 Hz.
  logic ref_clk = 1'b0; // System clock.
  logic resetn = 1'b0; // Reset, active low.
  sps_pkg::sps_params_s prm; // Parameter settings.
  logic [6:0] term_in = 7'h00; // Input terminal pins.
  logic [4:0][15:0] tv; // Measurement targets.
  logic [3:0] tf; // Flag targets.
  logic [15:0] cur, tcur, outf, cmdf, maxf; // Model measurements.
  logic [3:0] flg; // Model flags.
  logic [2:0] output_terminals; // Output terminal levels.
  sps_pkg::sps_action_e ramp_action; // Ramp request.
  logic fast_limit_block, stall_trip_fault, output_shutoff, operation_stop; // Outputs.
  int errors = 0; // Mismatch count.
  int tests_run = 0; // Comparison count.

  always #5 ref_clk = ~ref_clk; // 100 MHz clock.

  sps_drive_model model (.ref_clk(ref_clk), .resetn(resetn), .set_val(tv), .set_flag(tf),
    .output_current(cur), .torque_current(tcur), .output_freq(outf), .cmd_freq(cmdf),
    .max_freq(maxf), .flags(flg));

  sps_supervisor #(.MIN_ON_CYC(16), .TICK_CYC(10), .TRIP_CYC(50)) DUT (
    .ref_clk(ref_clk), .resetn(resetn), .params(prm), .output_current(cur),
    .torque_current(tcur), .output_freq(outf), .cmd_freq(cmdf), .max_freq(maxf),
    .regen(flg[0]), .regen_avoid_active(flg[1]), .ov_stall_active(flg[2]),
    .fast_limit_over(flg[3]), .input_terminals(term_in), .output_terminals(output_terminals),
    .ramp_action(ramp_action), .fast_limit_block(fast_limit_block),
    .stall_trip_fault(stall_trip_fault), .output_shutoff(output_shutoff),
    .operation_stop(operation_stop));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Compares one value and counts it.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits a number of edges, then steps past the edge so outputs are settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Drives one set of measurements and the selection code, then checks the ramp request.
  task automatic act(input string what, input logic [15:0] c, t, o, m, input logic [3:0] f,
    input logic [7:0] code, input sps_pkg::sps_action_e exp);
    @(posedge ref_clk);
    tv <= {16'h9C40, m, o, t, c};
    tf <= f;
    prm.per_phase_selection_code <= code;
    cyc(4);
    check(what, 16'(ramp_action), 16'(exp));
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short; a run this long counts as a mismatch.
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    test_done();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    prm = '0;
    prm.stall_level = 16'h05DC;
    prm.second_stall_level = 16'h270F;
    prm.high_freq_compensation_factor = 16'h270F;
    prm.reduction_start_frequency = 16'h1770;
    prm.status_output_timer = 16'h0000;
    prm.output_terminal_function_codes = {8'h00, 8'h67, 8'h03};
    prm.input_terminal_function_codes[0] = 8'h03;
    tv = {16'h9C40, f30, f30, 16'h0000, lo};
    tf = 4'h0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(2);
    check("idle terminals", 16'(output_terminals), 16'h0002);
    check("idle ramp", 16'(ramp_action), 16'(sps_pkg::SPS_ACT_RUN));
    $display("test reset finished");
    // A short stall keeps the status on for its minimum time, then drops it.
    act("short stall", hi, 0, f30, f40, 0, 0, sps_pkg::SPS_ACT_DEC);
    check("status on", 16'(output_terminals), 16'h0001);
    act("released", lo, 0, f30, f40, 0, 0, sps_pkg::SPS_ACT_RUN);
    check("min on", 16'(output_terminals), 16'h0001);
    cyc(20);
    check("status off", 16'(output_terminals), 16'h0002);
    act("constant", hi, 0, f30, f30, 0, 0, sps_pkg::SPS_ACT_DEC);
    act("decel", hi, 0, f40, f30, 0, 0, sps_pkg::SPS_ACT_ACC);
    act("at level", 16'h05DC, 0, f30, f40, 0, 0, sps_pkg::SPS_ACT_RUN);
    cyc(20);
    $display("test phases finished");
    // The timer delays the status; the never setting keeps it off.
    @(posedge ref_clk);
    prm.status_output_timer <= 16'h0002;
    act("timed stall", hi, 0, f30, f40, 0, 0, sps_pkg::SPS_ACT_DEC);
    check("timer early", 16'(output_terminals), 16'h0002);
    cyc(30);
    check("timer late", 16'(output_terminals), 16'h0001);
    act("timed drop", lo, 0, f30, f40, 0, 0, sps_pkg::SPS_ACT_RUN);
    cyc(25);
    @(posedge ref_clk);
    prm.status_output_timer <= 16'h270F;
    act("never stall", hi, 0, f30, f40, 0, 0, sps_pkg::SPS_ACT_DEC);
    cyc(40);
    check("timer never", 16'(output_terminals), 16'h0002);
    @(posedge ref_clk);
    prm.status_output_timer <= 16'h0000;
    act("avoid", lo, 0, f30, f30, 4'h2, 0, sps_pkg::SPS_ACT_RUN);
    check("avoid status", 16'(output_terminals), 16'h0001);
    act("ov stall", lo, 0, f30, f30, 4'h4, 0, sps_pkg::SPS_ACT_RUN);
    check("ov status", 16'(output_terminals), 16'h0001);
    act("quiet", lo, 0, f30, f30, 0, 0, sps_pkg::SPS_ACT_RUN);
    cyc(20);
    $display("test status finished");
    // Level zero, second level and its terminal.
    @(posedge ref_clk);
    prm.stall_level <= 16'h0000;
    act("level zero", 16'h07D0, 0, f30, f40, 0, 0, sps_pkg::SPS_ACT_RUN);
    check("zero status", 16'(output_terminals), 16'h0002);
    @(posedge ref_clk);
    prm.stall_level <= 16'h05DC;
    prm.second_stall_level <= 16'h03E8;
    term_in <= 7'h01;
    act("second level", 16'h04B0, 0, f30, f40, 0, 0, sps_pkg::SPS_ACT_DEC);
    @(posedge ref_clk);
    term_in <= 7'h02;
    act("other pin", 16'h04B0, 0, f30, f40, 0, 0, sps_pkg::SPS_ACT_RUN);
    @(posedge ref_clk);
    term_in <= 7'h00;
    act("select off", 16'h04B0, 0, f30, f40, 0, 0, sps_pkg::SPS_ACT_RUN);
    @(posedge ref_clk);
    prm.second_stall_level <= 16'h270F;
    $display("test levels finished");
    // Per-phase selection codes.
    act("code2 acc", hi, 0, f30, f40, 0, 8'h02, sps_pkg::SPS_ACT_RUN);
    act("code2 con", hi, 0, f30, f30, 0, 8'h02, sps_pkg::SPS_ACT_DEC);
    act("code4 con", hi, 0, f30, f30, 0, 8'h04, sps_pkg::SPS_ACT_RUN);
    act("code8 dec", hi, 0, f40, f30, 0, 8'h08, sps_pkg::SPS_ACT_RUN);
    act("code16", hi, 0, f30, f40, 0, 8'h10, sps_pkg::SPS_ACT_DEC);
    check("stop", 16'(operation_stop), 16'h0001);
    act("code0", hi, 0, f30, f40, 0, 8'h00, sps_pkg::SPS_ACT_DEC);
    check("continue", 16'(operation_stop), 16'h0000);
    act("drive 100", hi, 0, f40, f30, 0, 8'h64, sps_pkg::SPS_ACT_ACC);
    act("regen 100", hi, 0, f40, f30, 4'h1, 8'h64, sps_pkg::SPS_ACT_RUN);
    act("fast 100", lo, 0, f30, f30, 4'h8, 8'h64, sps_pkg::SPS_ACT_RUN);
    check("fast 100 block", 16'(fast_limit_block), 16'h0001);
    act("fast 101", lo, 0, f30, f30, 4'h8, 8'h65, sps_pkg::SPS_ACT_RUN);
    check("fast 101 block", 16'(fast_limit_block), 16'h0000);
    act("fast 1", lo, 0, f30, f30, 4'h8, 8'h01, sps_pkg::SPS_ACT_RUN);
    check("fast 1 block", 16'(fast_limit_block), 16'h0000);
    act("fast 0", lo, 0, f30, f30, 4'h8, 8'h00, sps_pkg::SPS_ACT_RUN);
    check("fast 0 block", 16'(fast_limit_block), 16'h0001);
    check("fast shutoff", 16'(output_shutoff), 16'h0001);
    $display("test codes finished");
    // Torque limit mode.
    @(posedge ref_clk);
    prm.limit_quantity_switch <= 1'b1;
    act("torque acc", 16'h01F4, 16'h0640, f30, f40, 0, 0, sps_pkg::SPS_ACT_DEC);
    act("torque low", 16'h0640, 16'h01F4, f30, f40, 0, 0, sps_pkg::SPS_ACT_RUN);
    act("torque 5hz", 16'h01F4, 16'h0640, 16'h01F4, 16'h0190, 0, 0,
      sps_pkg::SPS_ACT_RUN);
    act("torque 6hz", 16'h01F4, 16'h0640, 16'h0258, 16'h0190, 0, 0,
      sps_pkg::SPS_ACT_ACC);
    act("torque regen", 16'h01F4, 16'h0640, f30, f30, 4'h1, 0, sps_pkg::SPS_ACT_ACC);
    act("regen cap", 16'h01F4, 16'h0640, 16'h9C40, 16'h9C40, 4'h1, 0,
      sps_pkg::SPS_ACT_HOLD);
    // High-frequency reduction: at 120 Hz from 60 Hz the level halves to 75 %.
    @(posedge ref_clk);
    prm.limit_quantity_switch <= 1'b0;
    prm.high_freq_compensation_factor <= 16'h03E8;
    act("high freq", 16'h0320, 0, 16'h2EE0, 16'h32C8, 0, 0, sps_pkg::SPS_ACT_DEC);
    act("high below", 16'h02BC, 0, 16'h2EE0, 16'h32C8, 0, 0, sps_pkg::SPS_ACT_RUN);
    @(posedge ref_clk);
    prm.high_freq_compensation_factor <= 16'h270F;
    act("flat level", 16'h0320, 0, 16'h2EE0, 16'h32C8, 0, 0, sps_pkg::SPS_ACT_RUN);
    $display("test torque finished");
    // Stall held at 1 Hz trips and stays tripped until reset.
    act("low freq", hi, 0, 16'h0064, 16'h00C8, 0, 0, sps_pkg::SPS_ACT_DEC);
    check("no trip yet", 16'(stall_trip_fault), 16'h0000);
    cyc(60);
    check("trip", 16'(stall_trip_fault), 16'h0001);
    check("trip shutoff", 16'(output_shutoff), 16'h0001);
    act("trip held", lo, 0, f30, f30, 0, 0, sps_pkg::SPS_ACT_RUN);
    check("trip sticky", 16'(stall_trip_fault), 16'h0001);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(1);
    check("trip cleared", 16'(stall_trip_fault), 16'h0000);
    check("reset terminals", 16'(output_terminals), 16'h0002);
    $display("test trip finished");
    test_done();
  end
endmodule
